// >>> rtl/lpx_pkg.sv
// Shared constants and types for the LED port expander register slice
package lpx_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_MASK = 8'h06;
  localparam logic [7:0] ADDR_TEST = 8'h07;
  localparam logic [7:0] ADDR_CUR_FIRST = 8'h12;
  localparam logic [7:0] ADDR_CUR_LAST = 8'h1F;

  // ************************************************************
  // Field positions, sizes and reset values
  // ************************************************************
  localparam int FLAG_BIT = 7;
  localparam int TEST_BIT = 0;
  localparam int NUM_MON = 7;
  localparam int NUM_CUR_REGS = 14;
  localparam int NUM_SEGS = 28;
  localparam int NIB_W = 4;
  localparam int LEVEL_W = 5;
  localparam logic [6:0] MASK_RESET = 7'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic TEST_RESET = 1'b0;
  localparam logic [7:0] CUR_RESET = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_OFF = 5'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 5'h10;
  localparam logic [LEVEL_W-1:0] LEVEL_STEP = 5'h01;

  // ************************************************************
  // Link framing and bus address (address value is arbitrary)
  // ************************************************************
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int UPDATE_MAX_NS = 350;
  localparam int UPDATE_MAX_CYCLES = UPDATE_MAX_NS / CLK_PERIOD_NS;
  localparam int ARM_CYCLES = 3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef logic [LEVEL_W-1:0] lpx_level_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } lpx_wr_t;

  typedef enum {PH_IDLE, PH_ADDR, PH_PTR, PH_WDATA, PH_RDATA} lpx_phase_t;

endpackage : lpx_pkg

// >>> rtl/lpx_sync.sv
// Two flip-flop synchroniser for levels and toggles
module lpx_sync import lpx_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clock, // Destination clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic clk_en, // Freezes the stages while low
  input wire logic [WIDTH-1:0] d, // Asynchronous input
  output logic [WIDTH-1:0] q // Synchronised output
);

  logic [WIDTH-1:0] meta_reg;

  // Two stages, first one read only by the second
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_reg <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : lpx_sync

// >>> rtl/lpx_regs.sv
// LED port expander: serial link, mask/flag, test mode and segment current registers
module lpx_regs import lpx_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT // Bus address, arbitrary value
) (
  input wire logic clock, // System clock, 250 MHz
  input wire logic reset, // Reset, active high, synchronous in the core and asynchronous on the link side
  input wire logic clk_en, // Freezes core state while low
  input wire logic link_scl, // Serial link clock from the host
  input wire logic sda_in, // Serial data level seen on the wire
  output logic sda_out, // Serial data driven level, always low
  output logic sda_oe_n, // Low while pulling the data line low
  input wire logic [NUM_MON-1:0] port_in, // Monitored ports 24 to 30, from pins
  input wire logic [NUM_SEGS-1:0] seg_drive_en, // Segment enabled as LED driver
  output lpx_level_t [NUM_SEGS-1:0] seg_level, // Sink current in sixteenths, 0 is off
  output logic test_mode, // Display test mode active
  output logic change_flag // Transition change flag
);

  // ************************************************************
  // Link side, clocked by the serial clock and by the falling data line
  // ************************************************************
  lpx_phase_t phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic start_tog_reg;
  logic start_seen_reg;
  logic wr_tog_reg;
  logic rd_tog_reg;
  logic pull_reg;
  lpx_wr_t wr_cmd_reg;

  // Core side signals read by the link
  logic [7:0] rd_data_reg;

  // Link decode
  wire start_new = start_tog_reg != start_seen_reg;
  wire at_ack = bit_cnt_reg == ACK_BIT;
  wire addr_hit = shift_reg[7:1] == DEV_ADDR;
  wire ack_due = at_ack && ((phase_reg == PH_PTR) || (phase_reg == PH_WDATA) ||
                            ((phase_reg == PH_ADDR) && addr_hit));
  wire rd_bit = rd_data_reg[3'h7 - bit_cnt_reg[2:0]];
  wire [3:0] bit_cnt_inc = bit_cnt_reg + 4'h1;
  wire [7:0] ptr_inc = ptr_reg + 8'h01;

  // Start condition: data falls while clock is high
  always_ff @(negedge sda_in or posedge reset) begin
    if (reset) begin
      start_tog_reg <= 1'b0;
    end else if (link_scl) begin
      start_tog_reg <= ~start_tog_reg;
    end
  end

  // Bit sampling, byte framing and handover at the acknowledge rise
  always_ff @(posedge link_scl or posedge reset) begin
    if (reset) begin
      phase_reg <= PH_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      start_seen_reg <= 1'b0;
      wr_tog_reg <= 1'b0;
      rd_tog_reg <= 1'b0;
      wr_cmd_reg <= '0;
    end else if (start_new) begin
      start_seen_reg <= start_tog_reg;
      phase_reg <= PH_ADDR;
      shift_reg <= {7'h00, sda_in};
      bit_cnt_reg <= 4'h1;
    end else if (phase_reg != PH_IDLE) begin
      if (!at_ack) begin
        if (phase_reg != PH_RDATA) begin
          shift_reg <= {shift_reg[6:0], sda_in};
        end
        bit_cnt_reg <= bit_cnt_inc;
      end else begin
        bit_cnt_reg <= 4'h0;
        case (phase_reg)
          PH_ADDR: begin
            if (!addr_hit) begin
              phase_reg <= PH_IDLE;
            end else if (shift_reg[0]) begin
              phase_reg <= PH_RDATA;
              rd_tog_reg <= ~rd_tog_reg;
            end else begin
              phase_reg <= PH_PTR;
            end
          end
          PH_PTR: begin
            ptr_reg <= shift_reg;
            phase_reg <= PH_WDATA;
          end
          PH_WDATA: begin
            wr_cmd_reg <= '{addr: ptr_reg, data: shift_reg};
            wr_tog_reg <= ~wr_tog_reg;
            ptr_reg <= ptr_inc;
          end
          PH_RDATA: begin
            ptr_reg <= ptr_inc;
            if (sda_in) begin
              phase_reg <= PH_IDLE;
            end else begin
              rd_tog_reg <= ~rd_tog_reg;
            end
          end
          default: begin
            phase_reg <= PH_IDLE;
          end
        endcase
      end
    end
  end

  // Data line drive on the falling clock edge
  always_ff @(negedge link_scl or posedge reset) begin
    if (reset) begin
      pull_reg <= 1'b0;
    end else if (ack_due) begin
      pull_reg <= 1'b1;
    end else if ((phase_reg == PH_RDATA) && !at_ack) begin
      pull_reg <= ~rd_bit;
    end else begin
      pull_reg <= 1'b0;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = ~pull_reg;

  // ************************************************************
  // Crossings into the core clock
  // ************************************************************
  logic wr_tog_s;
  logic rd_tog_s;
  logic [NUM_MON-1:0] port_s;
  logic wr_tog_d_reg;
  logic rd_tog_d_reg;

  lpx_sync #(.WIDTH(1)) u_wr_sync (
    .clock(clock),
    .reset(reset),
    .clk_en(clk_en),
    .d(wr_tog_reg),
    .q(wr_tog_s)
  );

  lpx_sync #(.WIDTH(1)) u_rd_sync (
    .clock(clock),
    .reset(reset),
    .clk_en(clk_en),
    .d(rd_tog_reg),
    .q(rd_tog_s)
  );

  lpx_sync #(.WIDTH(NUM_MON)) u_port_sync (
    .clock(clock),
    .reset(reset),
    .clk_en(clk_en),
    .d(port_in),
    .q(port_s)
  );

  // Toggle edge detectors
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_tog_d_reg <= 1'b0;
      rd_tog_d_reg <= 1'b0;
    end else if (clk_en) begin
      wr_tog_d_reg <= wr_tog_s;
      rd_tog_d_reg <= rd_tog_s;
    end
  end

  // ************************************************************
  // Core registers
  // ************************************************************
  logic [NUM_MON-1:0] mask_reg;
  logic flag_reg;
  logic test_mode_reg;
  logic [7:0] cur_reg [NUM_CUR_REGS];
  logic [NUM_MON-1:0] port_d_reg;
  logic [1:0] arm_cnt_reg;
  lpx_level_t [NUM_SEGS-1:0] seg_level_reg;
  lpx_level_t [NUM_SEGS-1:0] seg_level_next;

  // Access decode
  wire wr_evt = wr_tog_s ^ wr_tog_d_reg;
  wire rd_evt = rd_tog_s ^ rd_tog_d_reg;
  wire [7:0] wr_addr = wr_cmd_reg.addr;
  wire [7:0] rd_addr = ptr_reg;
  wire wr_mask = wr_evt && (wr_addr == ADDR_MASK);
  wire wr_test = wr_evt && (wr_addr == ADDR_TEST);
  wire wr_cur = wr_evt && (wr_addr >= ADDR_CUR_FIRST) && (wr_addr <= ADDR_CUR_LAST);
  wire [3:0] wr_idx = 4'(wr_addr - ADDR_CUR_FIRST);
  wire rd_mask = rd_evt && (rd_addr == ADDR_MASK);
  wire rd_cur = (rd_addr >= ADDR_CUR_FIRST) && (rd_addr <= ADDR_CUR_LAST);
  wire [3:0] rd_idx = 4'(rd_addr - ADDR_CUR_FIRST);

  // Transition detection on enabled ports once synchronisers hold real levels
  wire armed = arm_cnt_reg == 2'(ARM_CYCLES);
  wire hit = armed && |((port_s ^ port_d_reg) & mask_reg);
  wire flag_next = hit ? 1'b1 : (rd_mask ? 1'b0 : flag_reg);

  // Read data selection
  wire [7:0] rd_data_next = (rd_addr == ADDR_MASK) ? {flag_reg, mask_reg} :
                            (rd_addr == ADDR_TEST) ? {7'h00, test_mode_reg} :
                            rd_cur ? cur_reg[rd_idx] : 8'h00;

  // Mask, flag and test mode
  always_ff @(posedge clock) begin
    if (reset) begin
      mask_reg <= MASK_RESET;
      flag_reg <= FLAG_RESET;
      test_mode_reg <= TEST_RESET;
    end else if (clk_en) begin
      flag_reg <= flag_next;
      if (wr_mask) begin
        mask_reg <= wr_cmd_reg.data[NUM_MON-1:0];
      end
      if (wr_test) begin
        test_mode_reg <= wr_cmd_reg.data[TEST_BIT];
      end
    end
  end

  // Segment current code storage
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < NUM_CUR_REGS; i++) begin
        cur_reg[i] <= CUR_RESET;
      end
    end else if (clk_en && wr_cur) begin
      cur_reg[wr_idx] <= wr_cmd_reg.data;
    end
  end

  // Port history, arming and read data snapshot
  always_ff @(posedge clock) begin
    if (reset) begin
      port_d_reg <= '0;
      arm_cnt_reg <= 2'h0;
      rd_data_reg <= 8'h00;
    end else if (clk_en) begin
      port_d_reg <= port_s;
      if (!armed) begin
        arm_cnt_reg <= arm_cnt_reg + 2'h1;
      end
      if (rd_evt) begin
        rd_data_reg <= rd_data_next;
      end
    end
  end

  // Current level per segment: off, code plus one sixteenths, or full in test
  always_comb begin
    for (int s = 0; s < NUM_SEGS; s++) begin
      if (test_mode_reg) begin
        seg_level_next[s] = LEVEL_FULL;
      end else if (seg_drive_en[s]) begin
        seg_level_next[s] = {1'b0, cur_reg[s / 2][(s % 2) * NIB_W +: NIB_W]} + LEVEL_STEP;
      end else begin
        seg_level_next[s] = LEVEL_OFF;
      end
    end
  end

  // Registered segment levels
  always_ff @(posedge clock) begin
    if (reset) begin
      seg_level_reg <= '0;
    end else if (clk_en) begin
      seg_level_reg <= seg_level_next;
    end
  end

  assign seg_level = seg_level_reg;
  assign test_mode = test_mode_reg;
  assign change_flag = flag_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Cycles a link write has waited for its core update
  logic [7:0] lat_cnt_reg;
  always_ff @(posedge clock) begin
    if (reset) begin
      lat_cnt_reg <= 8'h00;
    end else if (clk_en && (wr_tog_reg != wr_tog_d_reg)) begin
      lat_cnt_reg <= lat_cnt_reg + 8'h01;
    end else begin
      lat_cnt_reg <= 8'h00;
    end
  end

  AST_UPDATE_LATENCY: assert property (lat_cnt_reg <= 8'(UPDATE_MAX_CYCLES))
    else $error("register update later than allowed");
  AST_MASK_WRITE: assert property (clk_en && wr_mask |=>
    mask_reg == $past(wr_cmd_reg.data[NUM_MON-1:0]))
    else $error("mask write not applied");
  AST_FLAG_KEEP_ON_WRITE: assert property (clk_en && wr_mask && !hit && !rd_mask |=>
    flag_reg == $past(flag_reg))
    else $error("mask write disturbed the change flag");
  AST_MASK_READ: assert property (clk_en && rd_mask |=>
    rd_data_reg == {$past(flag_reg), $past(mask_reg)})
    else $error("mask read data wrong");
  AST_CLEAR_ON_READ: assert property (clk_en && rd_mask && !hit |=> !flag_reg)
    else $error("change flag not cleared by read");
  AST_TEST_SELECT: assert property (clk_en && wr_test |=>
    test_mode_reg == $past(wr_cmd_reg.data[TEST_BIT]))
    else $error("test mode bit not applied");
  AST_TEST_FULL: assert property (clk_en && test_mode_reg |=>
    seg_level_reg[NUM_SEGS-1] == LEVEL_FULL)
    else $error("test mode did not force full current");
  AST_SEG_STEP: assert property (clk_en && !test_mode_reg && seg_drive_en[1] |=>
    seg_level_reg[1] == {1'b0, $past(cur_reg[0][7:4])} + LEVEL_STEP)
    else $error("odd segment level wrong");
  AST_SEG_OFF: assert property (clk_en && !test_mode_reg && !seg_drive_en[0] |=>
    seg_level_reg[0] == LEVEL_OFF)
    else $error("disabled segment not off");
  AST_FLAG_SET: assert property (clk_en && hit |=> flag_reg)
    else $error("port change did not set flag");
  AST_FLAG_HOLD: assert property (clk_en && flag_reg && !rd_mask |=> flag_reg)
    else $error("change flag dropped without read");

endmodule : lpx_regs

// >>> dv/lpx_host.sv
// Host controller model that drives the two-wire link of the register slice
module lpx_host (
  output logic link_scl, // Link clock, stands high between frames
  output logic sda_oe_n, // Low while the host pulls data low
  input wire logic sda_in // Resolved data wire level
);
  timeunit 1ns;
  timeprecision 100ps;
  int half_ns = 24; // Half period of the 48 ns link clock
  realtime t_rise; // Latest bit sampling rise of the link clock

  // Idle bus: clock high, data released to its pull-up
  initial begin
    link_scl = 1'b1;
    sda_oe_n = 1'b1;
  end

  // One bit: data moves mid low phase, sampled at the rise
  task automatic put_bit(input logic b, output logic s);
    #(half_ns / 2);
    sda_oe_n = b;
    #(half_ns / 2);
    link_scl = 1'b1;
    t_rise = $realtime;
    s = sda_in;
    #(half_ns);
    link_scl = 1'b0;
  endtask : put_bit

  // Start or repeated start: data falls while the clock is high
  // Half ns step keeps link edges off the core clock grid
  task automatic start();
    #0.5;
    sda_oe_n = 1'b1;
    #(half_ns);
    link_scl = 1'b1;
    #(half_ns);
    sda_oe_n = 1'b0;
    #(half_ns);
    link_scl = 1'b0;
  endtask : start

  // Stop: data rises while the clock is high, then the bus idles
  task automatic stop();
    #(half_ns / 2);
    sda_oe_n = 1'b0;
    #(half_ns / 2);
    link_scl = 1'b1;
    #(half_ns);
    sda_oe_n = 1'b1;
    #(half_ns);
  endtask : stop

  // Eight bits MSB first, then the acknowledge bit (release with last high)
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], rx[i]);
    end
    put_bit(last, ack);
  endtask : xfer
endmodule : lpx_host

// >>> dv/lpx_regs_bench.sv
// Self-checking bench for the LED port expander register slice
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t got 0x%0h expected 0x%0h", $time, (g), (e)); end end

module lpx_regs_bench import lpx_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, reset, clk_en, link_scl, host_oe_n, sda_out, sda_oe_n, test_mode, change_flag;
  logic sda_in, ack;
  logic [7:0] rx;
  logic [7:0] cur[$];
  logic [NUM_MON-1:0] port_in;
  logic [NUM_SEGS-1:0] seg_drive_en;
  lpx_level_t [NUM_SEGS-1:0] seg_level;
  int errors, checks_done;

  // Open-drain data wire with pull-up
  assign sda_in = host_oe_n & (sda_oe_n | sda_out);

  // Core clock
  initial begin
    clock = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clock = ~clock;
  end

  lpx_regs i_lpx_regs (.clock(clock), .reset(reset), .clk_en(clk_en), .link_scl(link_scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .port_in(port_in),
    .seg_drive_en(seg_drive_en), .seg_level(seg_level), .test_mode(test_mode),
    .change_flag(change_flag));
  lpx_host i_lpx_host (.link_scl(link_scl), .sda_oe_n(host_oe_n), .sda_in(sda_in));

  // Address and pointer bytes of a frame
  task automatic frame_hdr(input logic [7:0] ptr);
    i_lpx_host.start();
    i_lpx_host.xfer({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rx, ack);
    `CHK(ack, 1'b0)
    i_lpx_host.xfer(ptr, 1'b1, rx, ack);
    `CHK(ack, 1'b0)
  endtask : frame_hdr

  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] q[$]);
    frame_hdr(ptr);
    foreach (q[k]) begin
      i_lpx_host.xfer(q[k], 1'b1, rx, ack);
      `CHK(ack, 1'b0)
    end
    i_lpx_host.stop();
    @(negedge clock);
  endtask : reg_wr

  // Pointer write, repeated start, one byte read with not-acknowledge
  task automatic reg_rd(input logic [7:0] ptr, input logic [7:0] exp);
    frame_hdr(ptr);
    i_lpx_host.start();
    i_lpx_host.xfer({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, rx, ack);
    i_lpx_host.xfer(8'hFF, 1'b1, rx, ack);
    i_lpx_host.stop();
    @(negedge clock);
    `CHK(rx, exp)
  endtask : reg_rd

  // Segment levels against the loaded code pattern (segment i holds i mod 16)
  task automatic chk_segs(input logic full);
    lpx_level_t exp_l;
    for (int i = 0; i < NUM_SEGS; i++) begin
      if (full) exp_l = LEVEL_FULL;
      else if (seg_drive_en[i]) exp_l = lpx_level_t'(i % 16) + LEVEL_STEP;
      else exp_l = LEVEL_OFF;
      `CHK(seg_level[i], exp_l)
    end
  endtask : chk_segs

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // Watchdog: tests need about 34 us of link traffic
  initial begin
    #100000;
    errors++;
    results();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    errors = 0;
    checks_done = 0;
    reset = 1'b0;
    clk_en = 1'b1;
    port_in = '0;
    seg_drive_en = '1;
    // Reset rises after time zero so the link flops see a clean edge
    @(negedge clock);
    reset = 1'b1;
    repeat (8) @(negedge clock);
    `CHK(test_mode, 1'b0)
    `CHK(change_flag, 1'b0)
    `CHK(seg_level, '0)
    reset = 1'b0;
    repeat (2) @(negedge clock);
    reg_rd(ADDR_MASK, 8'h00);
    reg_rd(ADDR_TEST, 8'h00);
    $display("test reset_values done");

    // Burst load of all current registers
    for (int k = 0; k < NUM_CUR_REGS; k++) cur.push_back({4'((2 * k + 1) % 16), 4'((2 * k) % 16)});
    reg_wr(ADDR_CUR_FIRST, cur);
    chk_segs(1'b0);
    seg_drive_en = 28'hAAAAAAA;
    repeat (3) @(negedge clock);
    chk_segs(1'b0);
    reg_rd(ADDR_CUR_FIRST, 8'h10);
    reg_rd(ADDR_CUR_LAST, 8'hBA);
    reg_rd(8'h08, 8'h00);
    // Frame to another bus address is ignored
    i_lpx_host.start();
    i_lpx_host.xfer({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, 1'b1, rx, ack);
    `CHK(ack, 1'b1)
    i_lpx_host.xfer(ADDR_TEST, 1'b1, rx, ack);
    i_lpx_host.xfer(8'h01, 1'b1, rx, ack);
    i_lpx_host.stop();
    @(negedge clock);
    `CHK(test_mode, 1'b0)
    $display("test currents done");

    reg_wr(ADDR_TEST, '{8'hFE});
    `CHK(test_mode, 1'b0)
    reg_rd(ADDR_TEST, 8'h00);
    fork
      reg_wr(ADDR_TEST, '{8'h01});
      begin
        wait (test_mode === 1'b1);
        `CHK(($realtime - i_lpx_host.t_rise) <= 350.0, 1'b1)
      end
    join
    repeat (2) @(negedge clock);
    chk_segs(1'b1);
    reg_rd(ADDR_TEST, 8'h01);
    reg_wr(ADDR_TEST, '{8'h00});
    chk_segs(1'b0);
    $display("test display_test done");

    reg_wr(ADDR_MASK, '{8'hFA});
    reg_rd(ADDR_MASK, 8'h7A);
    @(negedge clock);
    port_in[0] = 1'b1;
    repeat (10) @(negedge clock);
    `CHK(change_flag, 1'b0)
    port_in[1] = 1'b1;
    repeat (8) @(negedge clock);
    `CHK(change_flag, 1'b1)
    repeat (20) @(negedge clock);
    `CHK(change_flag, 1'b1)
    reg_rd(ADDR_MASK, 8'hFA);
    `CHK(change_flag, 1'b0)
    reg_rd(ADDR_MASK, 8'h7A);
    // Frozen core ignores a port change until the clock enable returns
    clk_en = 1'b0;
    port_in[3] = 1'b1;
    repeat (10) @(negedge clock);
    `CHK(change_flag, 1'b0)
    clk_en = 1'b1;
    repeat (8) @(negedge clock);
    `CHK(change_flag, 1'b1)
    $display("test change_flag done");
    results();
  end
endmodule : lpx_regs_bench
